/* File: core/sceh_od_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - an encoder fault is recorded as code 36 and an unsupported reference type as code 37.
// - history sub-entries 02h to 0Ah are read-only and hold older codes in the same encoding.
// - the sync identifier comes from bits 0-10, and bit 29 picks 11-bit or 29-bit form.
// - with bit 29 set, bits 11-28 form the upper part of the 29-bit identifier.
// - sync messages are produced only while bit 30 of the sync word is one.
// - the master reads and writes the sync word and the device applies it.
// - a constant read-only entry gives the hardware version text.
// - a constant read-only entry gives the software version text.
// - the history keeps at most ten records of signalled errors.
// - writing zero to the history count empties it; other values are refused.
// - code 0 means no error, other codes name the cause, such as 3 for tracking.
module sceh_od_top
  import sceh_pkg::*;
(
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_SYS_RST,
  input  wire sceh_req_t  I_REQ,
  input  wire logic       I_ERR_VALID,
  input  wire logic [7:0] I_ERR_CODE,
  input  wire logic       I_ENC_FAULT,
  input  wire logic       I_REF_UNSUP,
  input  wire logic       I_SYNC_TICK,
  output sceh_rsp_t       O_RSP,
  output sceh_sync_t      O_SYNC
);

  logic [7:0]  slot_code [HIST_DEPTH];
  logic [7:0]  slot_in   [HIST_DEPTH];
  logic        evt;
  logic [7:0]  evt_code;
  logic        clr;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [31:0] sync_cfg_q;
  logic [31:0] sync_cfg_d;
  sceh_rsp_t   rsp_q;
  sceh_rsp_t   rsp_d;
  sceh_sync_t  sync_q;
  sceh_sync_t  sync_d;
  logic        ext_sel;

  // event selection: an external emergency code beats the two local fault sources
  always_comb begin
    evt      = I_ERR_VALID | I_ENC_FAULT | I_REF_UNSUP;
    evt_code = ERR_NONE;
    if (I_ERR_VALID) begin
      evt_code = I_ERR_CODE;
    end else if (I_ENC_FAULT) begin
      evt_code = ERR_ENCODER;
    end else if (I_REF_UNSUP) begin
      evt_code = ERR_REF_UNSUP;
    end
  end

  // clear request: only a zero written to the count entry
  assign clr = I_REQ.valid && I_REQ.write && I_REQ.index == IDX_ERR_HIST
               && I_REQ.sub == SUB_COUNT && I_REQ.wdata == 32'h0000_0000;

  // slot inputs: an event in the clear cycle survives as the only entry
  always_comb begin
    slot_in[0] = evt ? evt_code : ERR_NONE;
    for (int k = 1; k < HIST_DEPTH; k++) begin
      slot_in[k] = clr ? ERR_NONE : slot_code[k-1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < HIST_DEPTH; g++) begin : g_slot
      sceh_hist_slot u_slot (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_SYS_RST),
        .i_load (evt | clr),
        .i_code (slot_in[g]),
        .o_code (slot_code[g])
      );
    end
  endgenerate

  // record count saturates at ten; oldest record falls off the end
  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = evt ? 8'h01 : 8'h00;
    end else if (evt && count_q != HIST_MAX) begin
      count_d = count_q + 8'h01;
    end
  end

  // sync word: written whole, bit 31 stored and read back but never used by the sync producer
  always_comb begin
    sync_cfg_d = sync_cfg_q;
    if (I_REQ.valid && I_REQ.write && I_REQ.index == IDX_SYNC_CFG && I_REQ.sub == SUB_COUNT) begin
      sync_cfg_d = I_REQ.wdata;
    end
  end

  // dictionary access: answer one cycle after the request, abort on anything illegal
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = I_REQ.valid;
    if (I_REQ.valid) begin
      unique case (I_REQ.index)
        IDX_ERR_HIST: begin
          if (I_REQ.sub == SUB_COUNT) begin
            rsp_d.abort = I_REQ.write && !clr;
            rsp_d.rdata = I_REQ.write ? 32'h0000_0000 : {24'h00_0000, count_q};
          end else if (I_REQ.sub >= SUB_FIRST && I_REQ.sub <= SUB_LAST) begin
            rsp_d.abort = I_REQ.write;
            rsp_d.rdata = I_REQ.write ? 32'h0000_0000
                          : {24'h00_0000, slot_code[4'(I_REQ.sub - SUB_FIRST)]};
          end else begin
            rsp_d.abort = 1'b1;
          end
        end
        IDX_SYNC_CFG: begin
          rsp_d.abort = I_REQ.sub != SUB_COUNT;
          rsp_d.rdata = (I_REQ.write || rsp_d.abort) ? 32'h0000_0000 : sync_cfg_q;
        end
        IDX_HW_VER: begin
          rsp_d.abort = I_REQ.write || I_REQ.sub != SUB_COUNT;
          rsp_d.rdata = rsp_d.abort ? 32'h0000_0000 : HW_VER_STR;
        end
        IDX_SW_VER: begin
          rsp_d.abort = I_REQ.write || I_REQ.sub != SUB_COUNT;
          rsp_d.rdata = rsp_d.abort ? 32'h0000_0000 : SW_VER_STR;
        end
        default: begin
          rsp_d.abort = 1'b1;
        end
      endcase
    end
  end

  // sync producer: identifier form follows bit 29, bit 31 is left out on purpose
  assign ext_sel = sync_cfg_q[SYNC_EXT_BIT];
  always_comb begin
    sync_d       = '0;
    sync_d.valid = I_SYNC_TICK && sync_cfg_q[SYNC_PROD_BIT];
    sync_d.ext   = ext_sel;
    sync_d.id    = {ext_sel ? sync_cfg_q[SYNC_EXT_MSB:SYNC_EXT_LSB] : 18'h0_0000,
                    sync_cfg_q[SYNC_ID_MSB:SYNC_ID_LSB]};
    sync_d.node  = SYNC_NODE_BCAST;
  end

  // state registers
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      count_q    <= 8'h00;
      sync_cfg_q <= SYNC_CFG_RST;
      rsp_q      <= '0;
      sync_q     <= '0;
    end else begin
      count_q    <= count_d;
      sync_cfg_q <= sync_cfg_d;
      rsp_q      <= rsp_d;
      sync_q     <= sync_d;
    end
  end

  assign O_RSP  = rsp_q;
  assign O_SYNC = sync_q;

  // checks
  sequence enc_only_s;
    I_ENC_FAULT && !I_ERR_VALID;
  endsequence

  sequence ref_only_s;
    I_REF_UNSUP && !I_ERR_VALID && !I_ENC_FAULT;
  endsequence

  enc_code_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    enc_only_s |=> slot_code[0] == ERR_ENCODER)
    else $error("encoder fault not recorded as 36");

  ref_code_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    ref_only_s |=> slot_code[0] == ERR_REF_UNSUP)
    else $error("reference type fault not recorded as 37");

  hist_shift_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (evt && !clr) |=> slot_code[1] == $past(slot_code[0]) && slot_code[9] == $past(slot_code[8]))
    else $error("history did not shift on a new error");

  hist_ro_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_REQ.valid && I_REQ.write && I_REQ.index == IDX_ERR_HIST
     && I_REQ.sub >= 8'h02 && I_REQ.sub <= SUB_LAST)
    |=> O_RSP.valid && O_RSP.abort)
    else $error("write to an old history slot was accepted");

  count_max_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    count_q <= HIST_MAX)
    else $error("history count above ten");

  hist_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (clr && !evt) |=> count_q == 8'h00 && slot_code[0] == ERR_NONE && slot_code[9] == ERR_NONE)
    else $error("history not emptied by a zero write");

  sync_off_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    !$past(sync_cfg_q[SYNC_PROD_BIT]) |-> !O_SYNC.valid)
    else $error("sync produced while producer bit is clear");

  sync_std_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_SYNC_TICK && sync_cfg_q[SYNC_PROD_BIT] && !sync_cfg_q[SYNC_EXT_BIT])
    |=> O_SYNC.valid && !O_SYNC.ext && O_SYNC.id[28:11] == 18'h0_0000 && O_SYNC.node == 7'h00)
    else $error("standard sync identifier wrong");

  sync_ext_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_SYNC_TICK && sync_cfg_q[SYNC_PROD_BIT] && sync_cfg_q[SYNC_EXT_BIT])
    |=> O_SYNC.valid && O_SYNC.id == $past(sync_cfg_q[28:0]))
    else $error("extended sync identifier wrong");

  sync_rw_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_REQ.valid && I_REQ.write && I_REQ.index == IDX_SYNC_CFG && I_REQ.sub == 8'h00)
    |=> sync_cfg_q == $past(I_REQ.wdata) && !O_RSP.abort)
    else $error("sync word write not applied");

  ver_ro_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_REQ.valid && !I_REQ.write && I_REQ.sub == 8'h00 && I_REQ.index == IDX_HW_VER)
    |=> O_RSP.valid && !O_RSP.abort && O_RSP.rdata == HW_VER_STR)
    else $error("hardware version read wrong");

  sw_ver_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (I_REQ.valid && !I_REQ.write && I_REQ.sub == 8'h00 && I_REQ.index == IDX_SW_VER)
    |=> O_RSP.valid && !O_RSP.abort && O_RSP.rdata == SW_VER_STR)
    else $error("software version read wrong");

  // a clear and an event in one cycle: the event must survive as the only record
  clr_evt_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (clr && evt)
    |=> count_q == 8'h01 && slot_code[0] == $past(evt_code) && slot_code[1] == ERR_NONE)
    else $error("event lost in a clearing cycle");

endmodule // sceh_od_top
`default_nettype wire

/* File: core/sceh_pkg.sv */
package sceh_pkg;

  // dictionary indices
  localparam logic [15:0] IDX_ERR_HIST = 16'h1003;
  localparam logic [15:0] IDX_SYNC_CFG = 16'h1005;
  localparam logic [15:0] IDX_HW_VER   = 16'h1009;
  localparam logic [15:0] IDX_SW_VER   = 16'h100A;

  // error history layout
  localparam int          HIST_DEPTH   = 10;
  localparam logic [7:0]  SUB_COUNT    = 8'h00;
  localparam logic [7:0]  SUB_FIRST    = 8'h01;
  localparam logic [7:0]  SUB_LAST     = 8'h0A;
  localparam logic [7:0]  HIST_MAX     = 8'h0A;
  localparam logic [7:0]  ERR_NONE     = 8'h00;
  localparam logic [7:0]  ERR_TRACKING = 8'h03;
  localparam logic [7:0]  ERR_ENCODER  = 8'h24;
  localparam logic [7:0]  ERR_REF_UNSUP = 8'h25;

  // sync configuration word fields
  localparam int          SYNC_ID_LSB    = 0;
  localparam int          SYNC_ID_MSB    = 10;
  localparam int          SYNC_EXT_LSB   = 11;
  localparam int          SYNC_EXT_MSB   = 28;
  localparam int          SYNC_EXT_BIT   = 29;
  localparam int          SYNC_PROD_BIT  = 30;
  localparam logic [31:0] SYNC_CFG_RST   = 32'h0000_0000;
  localparam logic [6:0]  SYNC_NODE_BCAST = 7'h00;

  // version strings, four characters, first character in the low byte; values arbitrary
  localparam logic [31:0] HW_VER_STR   = 32'h3130_5748;
  localparam logic [31:0] SW_VER_STR   = 32'h3130_5753;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } sceh_req_t;

  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] rdata;
  } sceh_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic [28:0] id;
    logic [6:0]  node;
  } sceh_sync_t;

endpackage

/* File: core/sceh_hist_slot.sv */
`timescale 1ns/1ps
`default_nettype none
// one error-history slot: loads a new code or holds
module sceh_hist_slot
  import sceh_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_code,
  output logic      [7:0] o_code
);

  logic [7:0] code_q;
  logic [7:0] code_d;

  // next value
  always_comb begin
    code_d = i_load ? i_code : code_q;
  end

  // register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code_q <= ERR_NONE;
    end else begin
      code_q <= code_d;
    end
  end

  assign o_code = code_q;

endmodule // sceh_hist_slot
`default_nettype wire

/* File: verif/sceh_master.sv */
`timescale 1ns/1ps
`default_nettype none
// network master model: one dictionary request at a time, answer awaited within a bound
module sceh_master
  import sceh_pkg::*;
(
  input  wire logic      i_clk,
  input  wire sceh_rsp_t i_rsp,
  output sceh_req_t      o_req
);
  initial o_req = '0;
  // request held through the taking edge, then scrambled so stale fields never look valid
  // the count entry only ever gets zero except where a refusal is wanted
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [31:0] wd, output logic ab, output logic [31:0] rd,
                      output logic ok);
    int n;
    o_req = '{1'h1, wr, idx, sb, wd};
    @(posedge i_clk);
    #1;
    o_req = '{1'h0, ~wr, ~idx, ~sb, ~wd};
    n = 0;
    while (i_rsp.valid !== 1'h1 && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    ok = (i_rsp.valid === 1'h1);
    ab = i_rsp.abort;
    rd = i_rsp.rdata;
  endtask
endmodule // sceh_master
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import sceh_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [15:0] idx;
    logic [7:0]  sb;
    logic [31:0] wd;
    logic        ab;
    logic [31:0] rd;
  } sceh_row_t;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       ev_err = 1'h0;
  logic       ev_enc = 1'h0;
  logic       ev_ref = 1'h0;
  logic       tick = 1'h0;
  logic [7:0] ev_code = 8'h00;
  logic       ab;
  logic       ok;
  logic [31:0] rd;
  logic [7:0] exp_h [12];
  sceh_row_t  rows [10];
  sceh_req_t  req;
  sceh_rsp_t  rsp;
  sceh_sync_t syn;
  int         num_errors = 0;
  int         checks = 0;

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  sceh_od_top dut_u (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_REQ(req), .I_ERR_VALID(ev_err),
    .I_ERR_CODE(ev_code), .I_ENC_FAULT(ev_enc), .I_REF_UNSUP(ev_ref), .I_SYNC_TICK(tick),
    .O_RSP(rsp), .O_SYNC(syn));
  sceh_master mst_u (.i_clk(clk), .i_rsp(rsp), .o_req(req));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // a missing answer is a hang, so the run is closed at once
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sb,
                     input logic [31:0] wd);
    mst_u.xfer(wr, idx, sb, wd, ab, rd, ok);
    if (ok !== 1'h1) begin
      num_errors++;
      $display("[FAIL] answer expected 1 seen 0");
      end_sim();
    end
  endtask

  // write the sync word, pulse the tick, look at the send request one cycle on
  task automatic sync_chk(input logic [31:0] w, input logic v, input logic x,
                          input logic [28:0] id);
    acc(1'h1, IDX_SYNC_CFG, 8'h00, w);
    tick = 1'h1;
    @(posedge clk);
    #1;
    tick = 1'h0;
    chk("sync valid", {31'h0, v}, {31'h0, syn.valid});
    if (v) begin
      chk("sync ext", {31'h0, x}, {31'h0, syn.ext});
      chk("sync id", {3'h0, id}, {3'h0, syn.id});
      chk("sync node", 32'h0, {25'h0, syn.node});
    end
  endtask

  // watchdog so no run outlives its budget
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    rows[0] = '{1'h1, IDX_SYNC_CFG, 8'h00, 32'hC000_0123, 1'h0, 32'h0};
    rows[1] = '{1'h0, IDX_SYNC_CFG, 8'h00, 32'h0, 1'h0, 32'hC000_0123};
    rows[2] = '{1'h0, IDX_HW_VER, 8'h00, 32'h0, 1'h0, HW_VER_STR};
    rows[3] = '{1'h0, IDX_SW_VER, 8'h00, 32'h0, 1'h0, SW_VER_STR};
    rows[4] = '{1'h1, IDX_HW_VER, 8'h00, 32'h0, 1'h1, 32'h0};
    rows[5] = '{1'h1, IDX_ERR_HIST, 8'h02, 32'h11, 1'h1, 32'h0};
    rows[6] = '{1'h1, IDX_ERR_HIST, 8'h00, 32'h5, 1'h1, 32'h0};
    rows[7] = '{1'h0, IDX_ERR_HIST, 8'h00, 32'h0, 1'h0, 32'h0};
    rows[8] = '{1'h0, IDX_ERR_HIST, 8'h0B, 32'h0, 1'h1, 32'h0};
    rows[9] = '{1'h0, 16'h2000, 8'h00, 32'h0, 1'h1, 32'h0};
    repeat (3) @(posedge clk);
    #1;
    rst = 1'h0;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].idx, rows[i].sb, rows[i].wd);
      chk("abort", {31'h0, rows[i].ab}, {31'h0, ab});
      if (!rows[i].wr) chk("rdata", rows[i].rd, rd);
    end
    $display("test table done");
    // twelve events overflow the ten slots; the last three carry local fault sources, the first two of them clashing,
    // so the two local fault codes are still held when the slots are read back
    for (int i = 0; i < 12; i++) begin
      ev_enc = (i == 9 || i == 10);
      ev_ref = (i >= 10);
      ev_err = (i < 10);
      ev_code = 8'(i + 1);
      exp_h[i] = (i == 10) ? 8'h24 : (i == 11) ? 8'h25 : 8'(i + 1);
      @(posedge clk);
      #1;
    end
    ev_enc = 1'h0;
    ev_ref = 1'h0;
    ev_err = 1'h0;
    acc(1'h0, IDX_ERR_HIST, 8'h00, 32'h0);
    chk("count", 32'h0000_000A, rd);
    for (int k = 1; k <= 10; k++) begin
      acc(1'h0, IDX_ERR_HIST, 8'(k), 32'h0);
      chk("slot", {24'h0, exp_h[12 - k]}, rd);
    end
    acc(1'h1, IDX_ERR_HIST, 8'h00, 32'h0);
    chk("clear abort", 32'h0, {31'h0, ab});
    acc(1'h0, IDX_ERR_HIST, 8'h00, 32'h0);
    chk("count", 32'h0, rd);
    acc(1'h0, IDX_ERR_HIST, 8'h01, 32'h0);
    chk("slot", 32'h0, rd);
    // one record, then a clear taken with an encoder fault: the fault is the only record left
    ev_err = 1'h1;
    ev_code = 8'h05;
    @(posedge clk);
    #1;
    ev_err = 1'h0;
    ev_enc = 1'h1;
    fork
      acc(1'h1, IDX_ERR_HIST, 8'h00, 32'h0);
      begin
        @(posedge clk);
        #1;
        ev_enc = 1'h0;
      end
    join
    chk("clash abort", 32'h0, {31'h0, ab});
    acc(1'h0, IDX_ERR_HIST, 8'h00, 32'h0);
    chk("count", 32'h1, rd);
    acc(1'h0, IDX_ERR_HIST, 8'h01, 32'h0);
    chk("slot", 32'h24, rd);
    acc(1'h0, IDX_ERR_HIST, 8'h02, 32'h0);
    chk("slot", 32'h0, rd);
    $display("test history done");
    sync_chk(32'h4FFF_FFFF, 1'h1, 1'h0, 29'h0000_07FF);
    sync_chk(32'h7234_5678, 1'h1, 1'h1, 29'h1234_5678);
    sync_chk(32'hF234_5678, 1'h1, 1'h1, 29'h1234_5678);
    sync_chk(32'hB234_5678, 1'h0, 1'h0, 29'h0);
    $display("test sync done");
    rst = 1'h1;
    @(posedge clk);
    #1;
    rst = 1'h0;
    acc(1'h0, IDX_SYNC_CFG, 8'h00, 32'h0);
    chk("sync word", 32'h0, rd);
    // the history held one record before the reset; it must come back empty
    acc(1'h0, IDX_ERR_HIST, 8'h00, 32'h0);
    chk("count", 32'h0, rd);
    acc(1'h0, IDX_ERR_HIST, 8'h01, 32'h0);
    chk("slot", 32'h0, rd);
    $display("test reset done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
